// file: bench/dcc_core_model.sv
// Purpose: stand-in for the conversion core, captures each loaded channel set
// Assumes: o_core_valid is a one-cycle pulse after the fine codes settle
// Notes: behavioural; it never stalls, since the core side has no handshake
`timescale 1ns/1ps
module dcc_core_model
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // from the trim block
   input wire dcc_pkg::dcc_core_t [dcc_pkg::NCH-1:0] i_core,
   input wire logic i_core_valid,
   // captured conversion set
   output dcc_pkg::dcc_core_t [dcc_pkg::NCH-1:0] o_cap
);
   // capture on the valid pulse, like the core's own latch would
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         o_cap <= '0;
      end
      else if (i_core_valid)
      begin
         o_cap <= i_core;
      end
   end
endmodule : dcc_core_model

// file: bench/tb.sv
// Purpose: self-checking bench for the channel code trim block
// Assumes: 200 MHz clock, synchronous active-low reset held 3 cycles
// Notes: expected fine codes come from a reference model of the trim math
`timescale 1ns/1ps
module tb;
   import dcc_pkg::*;
   logic i_clock;
   logic i_resetn;
   logic i_reg_wr;
   logic i_reg_rd;
   logic [ADDR_W-1:0] i_reg_addr;
   logic [WORD_W-1:0] i_reg_wdata;
   logic [WORD_W-1:0] o_reg_rdata;
   logic o_reg_rvalid;
   logic i_bipolar;
   logic [NCH-1:0] i_range_x4;
   logic i_load;
   dcc_core_t [NCH-1:0] o_core;
   logic o_core_valid;
   dcc_core_t [NCH-1:0] cap;
   int fail_count;
   int cmp_count;
   int cycles;
   logic [WORD_W-1:0] rdat;
   logic [CODE_W-1:0] code [NCH];
   logic [OFF_W-1:0] off [NCH];
   logic [SLP_W-1:0] slp [NCH];

   dcc_top dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_bipolar(i_bipolar),
      .i_range_x4(i_range_x4), .i_load(i_load), .o_core(o_core),
      .o_core_valid(o_core_valid));

   dcc_core_model core (.i_clock(i_clock), .i_resetn(i_resetn), .i_core(o_core),
      .i_core_valid(o_core_valid), .o_cap(cap));

   // 5 ns period
   initial
   begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   // hang guard: well above the ~1200 cycles the sequence needs
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
   endtask : wr

   // read strobe, then wait a bounded time for the answer
   task automatic rd(input logic [3:0] a);
      @(posedge i_clock);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clock);
      i_reg_rd <= 1'b0;
      rdat = 'x;
      for (int i = 0; i < 4; i++)
      begin
         #1;
         if (o_reg_rvalid === 1'b1)
         begin
            rdat = o_reg_rdata;
            break;
         end
         @(posedge i_clock);
      end
   endtask : rd

   // reference trim math in 1/32 code step units, clamped to the code range
   function automatic logic [FINE_W-1:0] exp_fine(input logic bip,
      input logic [CODE_W-1:0] c, input logic [OFF_W-1:0] o, input logic [SLP_W-1:0] g);
      longint s;
      longint sum;
      s = bip ? longint'($signed(c)) : longint'(c);
      sum = s * 32 + ((s * longint'($signed(g))) >>> (bip ? 10 : 11)) + longint'($signed(o));
      if (bip)
         sum = (sum > 262143) ? 262143 : ((sum < -262144) ? -262144 : sum);
      else
         sum = (sum > 524287) ? 524287 : ((sum < 0) ? 0 : sum);
      return sum[FINE_W-1:0];
   endfunction : exp_fine

   initial
   begin
      i_resetn = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = '0;
      i_reg_wdata = '0;
      i_bipolar = 1'b0;
      i_range_x4 = '0;
      i_load = 1'b0;
      void'($urandom(94700));
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      // trims come up as zero
      for (int n = 0; n < NCH; n++)
      begin
         rd(4'(4 + n));
         check("offset reset", rdat, 32'h0);
         rd(4'(8 + n));
         check("slope reset", rdat, 32'h0);
      end
      // upper trim bits and low data bits are dropped; unmapped reads zero
      wr(4'h5, 16'hffff);
      rd(4'h5);
      check("offset upper bits", rdat, 32'h01ff);
      wr(4'h9, 16'hffff);
      rd(4'h9);
      check("slope upper bits", rdat, 32'h00ff);
      rd(4'h4);
      check("offset per channel", rdat, 32'h0);
      wr(4'h2, 16'hffff);
      rd(4'h2);
      check("data low bits", rdat, 32'hfffc);
      wr(4'hc, 16'hffff);
      rd(4'hc);
      check("unmapped read", rdat, 32'h0);
      // corners first, then random codes, trims and modes
      for (int it = 0; it < 40; it++)
      begin
         for (int n = 0; n < NCH; n++)
         begin
            code[n] = 14'($urandom);
            off[n] = 9'($urandom);
            slp[n] = 8'($urandom);
            if (it < 6)
            begin
               // extremes exercise saturation and trim limits; zero slope isolates offset
               code[n] = (n == 0) ? 14'h1fff : (n == 1) ? 14'h2000 : (n == 2) ? 14'h3fff : 14'h0;
               off[n] = it[0] ? 9'h100 : 9'h0ff;
               slp[n] = it[2] ? 8'h00 : it[1] ? 8'h80 : 8'h7f;
            end
            wr(4'(n), {code[n], 2'($urandom)});
            wr(4'(4 + n), {7'($urandom), off[n]});
            wr(4'(8 + n), {8'($urandom), slp[n]});
         end
         @(posedge i_clock);
         i_bipolar <= (it < 6) ? it[0] : 1'($urandom);
         i_range_x4 <= 4'($urandom);
         i_load <= 1'b1;
         @(posedge i_clock);
         i_load <= 1'b0;
         for (int i = 0; i < 6; i++)
         begin
            #1;
            if (o_core_valid === 1'b1)
               break;
            @(posedge i_clock);
         end
         check("core valid", o_core_valid, 32'h1);
         @(posedge i_clock);
         #1;
         for (int n = 0; n < NCH; n++)
         begin
            check("fine code", cap[n].fine, exp_fine(i_bipolar, code[n], off[n], slp[n]));
            check("range copy", cap[n].range_x4, i_range_x4[n]);
            check("mode copy", cap[n].bipolar, i_bipolar);
         end
      end
      end_of_test();
   end
endmodule : tb

// file: core/dcc_corr.sv
// Purpose: one channel of offset and slope correction with saturation
// Assumes: trims and code are stable flops of the same clock
// Notes: result has five fraction bits; one cycle of latency
`timescale 1ns/1ps
module dcc_corr
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // operands
   input wire logic i_bipolar,
   input wire logic [dcc_pkg::CODE_W-1:0] i_code,
   input wire logic [dcc_pkg::OFF_W-1:0] i_offset,
   input wire logic [dcc_pkg::SLP_W-1:0] i_slope,
   // corrected code
   output logic [dcc_pkg::FINE_W-1:0] o_fine
);
   import dcc_pkg::*;

   logic signed [CODE_W:0] code_s; // code as signed value
   logic signed [SUM_W-1:0] prod; // code times slope trim
   logic signed [SUM_W-1:0] slope_adj; // slope term in 1/32 steps
   logic signed [SUM_W-1:0] sum; // unclamped fine code
   logic signed [SUM_W-1:0] lo, hi; // limits of the active mode
   logic [FINE_W-1:0] fine_q, fine_d; // registered result

   // correction arithmetic
   always_comb
   begin
      // twos complement in bipolar, straight binary in unipolar
      if (i_bipolar)
      begin
         code_s = {i_code[CODE_W-1], i_code};
      end
      else
      begin
         code_s = {1'b0, i_code};
      end
      // slope moves the end point by trim/4 steps: scales with the code
      prod = SUM_W'(code_s) * SUM_W'($signed(i_slope));
      if (i_bipolar)
      begin
         slope_adj = prod >>> SLP_SHIFT_BIP;
         lo = FINE_BIP_MIN;
         hi = FINE_BIP_MAX;
      end
      else
      begin
         slope_adj = prod >>> SLP_SHIFT_UNI;
         lo = FINE_UNI_MIN;
         hi = FINE_UNI_MAX;
      end
      // offset is a constant shift in 1/32 steps, signed in both modes
      sum = (SUM_W'(code_s) <<< FRAC_W) + slope_adj
            + SUM_W'($signed(i_offset));
      // clip instead of wrapping so a trim never flips the output
      if (sum < lo)
      begin
         fine_d = lo[FINE_W-1:0];
      end
      else if (sum > hi)
      begin
         fine_d = hi[FINE_W-1:0];
      end
      else
      begin
         fine_d = sum[FINE_W-1:0];
      end
   end

   // result register
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         fine_q <= '0;
      end
      else
      begin
         fine_q <= fine_d;
      end
   end

   assign o_fine = fine_q;

   // untrimmed code passes as code * 32
   AST_PLAIN_CODE: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_offset == 9'h000 && i_slope == 8'h00 && !i_bipolar)
      |=> o_fine == {$past(i_code), 5'h00})
      else $error("untrimmed unipolar code not passed through");

   // a negative offset in bipolar at code zero gives a negative result
   AST_OFF_SIGNED: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_bipolar && i_code == 14'h0000 && i_slope == 8'h00 && i_offset == 9'h100)
      |=> o_fine == 19'h7ff00)
      else $error("offset trim not read as twos complement");

   // slope trim leaves the zero code untouched in bipolar
   AST_SLOPE_PIVOT: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_bipolar && i_code == 14'h0000)
      |=> o_fine == FINE_W'($signed($past(i_offset))))
      else $error("slope trim moved the bipolar zero point");

   // offset shifts an unclamped code by exactly the trim value
   AST_OFF_SHIFT: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (!i_bipolar && i_slope == 8'h00 && i_code == 14'h0100 && i_offset == 9'h01f)
      |=> o_fine == 19'h0201f)
      else $error("offset trim did not shift the code");

   // saturation at the top of the unipolar range
   AST_SAT_HIGH: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (!i_bipolar && i_code == 14'h3fff && i_offset == 9'h0ff && i_slope == 8'h00)
      |=> o_fine == 19'h7ffff)
      else $error("unipolar overflow not clamped");

   // bipolar negative full scale with code 0x2000
   AST_BIP_NEG_FS: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_bipolar && i_code == 14'h2000 && i_offset == 9'h000 && i_slope == 8'h00)
      |=> o_fine == 19'h40000)
      else $error("bipolar negative full scale wrong");
endmodule : dcc_corr

// file: core/dcc_pkg.sv
// Purpose: shared constants, types and decode for the channel code trim block
// Assumes: one 200 MHz clock, register writes arrive from same-clock framing logic
// Notes: fine codes carry five fraction bits of one code step
package dcc_pkg;
   // channel count and widths
   localparam int NCH = 4;
   localparam int WORD_W = 16;
   localparam int CODE_W = 14;
   localparam int OFF_W = 9;
   localparam int SLP_W = 8;
   localparam int FRAC_W = 5;
   localparam int FINE_W = 19;
   localparam int ADDR_W = 4;
   localparam int SUM_W = 23;
   // code field position inside the data word
   localparam int CODE_MSB = 15;
   localparam int CODE_LSB = 2;
   // gain trim step is 1/4 code step at the end point; the shift folds in the
   // half-range (bipolar, 8192) or full-range (unipolar, 16384) denominator
   localparam int SLP_SHIFT_BIP = 10;
   localparam int SLP_SHIFT_UNI = 11;
   // register index map, one word per register
   localparam logic [3:0] ADDR_DATA_BASE = 4'h0;
   localparam logic [3:0] ADDR_OFF_BASE = 4'h4;
   localparam logic [3:0] ADDR_SLP_BASE = 4'h8;
   // reset values
   localparam logic [CODE_W-1:0] DATA_RESET = 14'h0000;
   localparam logic [OFF_W-1:0] OFF_RESET = 9'h000;
   localparam logic [SLP_W-1:0] SLP_RESET = 8'h00;
   // saturation limits in 1/32 code step units
   localparam logic signed [SUM_W-1:0] FINE_BIP_MIN = -23'sh040000;
   localparam logic signed [SUM_W-1:0] FINE_BIP_MAX = 23'sh03ffff;
   localparam logic signed [SUM_W-1:0] FINE_UNI_MIN = 23'sh000000;
   localparam logic signed [SUM_W-1:0] FINE_UNI_MAX = 23'sh07ffff;

   // register kind selected by an address
   typedef enum logic [1:0] {DCC_SEL_DATA, DCC_SEL_OFF, DCC_SEL_SLP, DCC_SEL_NONE} dcc_sel_t;

   // decoded address
   typedef struct packed {
      dcc_sel_t sel;
      logic [1:0] chan;
   } dcc_dec_t;

   // one channel toward the conversion core
   typedef struct packed {
      logic range_x4;
      logic bipolar;
      logic [FINE_W-1:0] fine;
   } dcc_core_t;

   // shared by the write and the read path
   function automatic dcc_dec_t dcc_decode(input logic [ADDR_W-1:0] addr);
      dcc_dec_t dec;
      dec.chan = addr[1:0];
      case (addr[3:2])
         ADDR_DATA_BASE[3:2]: dec.sel = DCC_SEL_DATA;
         ADDR_OFF_BASE[3:2]: dec.sel = DCC_SEL_OFF;
         ADDR_SLP_BASE[3:2]: dec.sel = DCC_SEL_SLP;
         default: dec.sel = DCC_SEL_NONE;
      endcase
      return dec;
   endfunction : dcc_decode
endpackage : dcc_pkg

// file: core/dcc_top.sv
// Purpose: channel code registers, load latch and per-channel code trim
// Assumes: register port and load strobe come from same-clock framing logic
// Notes: reads answer one cycle after the strobe
//    trim readback follows the address between reads, so take it on rvalid
//    range and mode bits pass straight through to the core, unregistered
// Operation
// - bipolar code read as twos complement
// - unipolar code read as straight binary
// - separate offset and slope trim per channel
// - offset trim resets to zero
// - offset trim is nine low bits, 1/32 step
// - offset trim is signed in both modes
// - unused trim bits ignore writes, read zero
// - slope trim resets to zero
// - slope trim is eight low bits, 1/4 step
// - slope trim is signed in both modes
// - offset trim shifts whole transfer function
// - slope trim moves the full-scale end point
// - channel code is data word bits 15..2
// - range bit picks gain four or two
`timescale 1ns/1ps
module dcc_top
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [dcc_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [dcc_pkg::WORD_W-1:0] i_reg_wdata,
   output logic [dcc_pkg::WORD_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // configuration
   input wire logic i_bipolar,
   input wire logic [dcc_pkg::NCH-1:0] i_range_x4,
   input wire logic i_load,
   // toward the conversion core
   output dcc_pkg::dcc_core_t [dcc_pkg::NCH-1:0] o_core,
   output logic o_core_valid
);
   import dcc_pkg::*;

   dcc_dec_t wr_dec; // decoded write address
   dcc_dec_t rd_dec; // decoded read address
   logic [NCH-1:0][CODE_W-1:0] data_q, data_d; // input data codes
   logic [NCH-1:0][CODE_W-1:0] latch_q, latch_d; // codes in conversion
   logic [WORD_W-1:0] data_rd_q, data_rd_d; // registered code readback
   dcc_sel_t rd_sel_q, rd_sel_d; // kind of the pending read
   logic rvalid_q, rvalid_d; // read answer strobe
   logic load_q, load_d; // load seen, result one cycle on
   logic valid_q, valid_d; // result strobe toward the core
   logic [WORD_W-1:0] bank_rd; // trim readback from the bank
   logic [NCH-1:0][OFF_W-1:0] offset; // live offset trims
   logic [NCH-1:0][SLP_W-1:0] slope; // live slope trims
   logic [NCH-1:0][FINE_W-1:0] fine; // corrected codes

   // address decode for both directions
   always_comb
   begin
      wr_dec = dcc_decode(i_reg_addr);
      rd_dec = dcc_decode(i_reg_addr);
   end

   // data registers take the code field only; low two bits are dropped
   always_comb
   begin
      data_d = data_q;
      if (i_reg_wr && wr_dec.sel == DCC_SEL_DATA)
      begin
         data_d[wr_dec.chan] = i_reg_wdata[CODE_MSB:CODE_LSB];
      end
   end

   // load copies all input codes into the latch at once
   // a write in the load cycle lands after the copy, so the latch keeps the old code
   always_comb
   begin
      latch_d = latch_q;
      load_d = i_load;
      valid_d = load_q;
      if (i_load)
      begin
         latch_d = data_q;
      end
   end

   // read capture; trims are read inside the bank on the same edge
   always_comb
   begin
      rvalid_d = i_reg_rd;
      rd_sel_d = rd_sel_q;
      data_rd_d = data_rd_q;
      if (i_reg_rd)
      begin
         rd_sel_d = rd_dec.sel;
         if (rd_dec.sel == DCC_SEL_DATA)
         begin
            // code returns in its field, low bits read zero
            data_rd_d = {data_q[rd_dec.chan], {CODE_LSB{1'b0}}};
         end
         else
         begin
            data_rd_d = '0;
         end
      end
   end

   // control and data registers
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         data_q <= {NCH{DATA_RESET}};
         latch_q <= {NCH{DATA_RESET}};
         data_rd_q <= '0;
         rd_sel_q <= DCC_SEL_NONE;
         rvalid_q <= 1'b0;
         load_q <= 1'b0;
         valid_q <= 1'b0;
      end
      else
      begin
         data_q <= data_d;
         latch_q <= latch_d;
         data_rd_q <= data_rd_d;
         rd_sel_q <= rd_sel_d;
         rvalid_q <= rvalid_d;
         load_q <= load_d;
         valid_q <= valid_d;
      end
   end

   // trim storage, one entry per channel
   dcc_trim_bank u_bank (
      .i_clock (i_clock),
      .i_resetn (i_resetn),
      .i_off_we (i_reg_wr && wr_dec.sel == DCC_SEL_OFF),
      .i_slp_we (i_reg_wr && wr_dec.sel == DCC_SEL_SLP),
      .i_wr_chan (wr_dec.chan),
      .i_wdata (i_reg_wdata),
      .i_rd_chan (rd_dec.chan),
      .i_rd_sel (rd_dec.sel),
      .o_rd_data (bank_rd),
      .o_offset (offset),
      .o_slope (slope)
   );

   // one correction datapath per channel, all running in parallel
   for (genvar ch = 0; ch < NCH; ch++)
   begin : g_chan
      dcc_corr u_corr (
         .i_clock (i_clock),
         .i_resetn (i_resetn),
         .i_bipolar (i_bipolar),
         .i_code (latch_q[ch]),
         .i_offset (offset[ch]),
         .i_slope (slope[ch]),
         .o_fine (fine[ch])
      );
      // range bit travels with the code; the core scales full scale by it
      assign o_core[ch].range_x4 = i_range_x4[ch];
      assign o_core[ch].bipolar = i_bipolar;
      assign o_core[ch].fine = fine[ch];

      // every channel carries its own range bit and the shared mode flag
      AST_RANGE_CH: assert property (@(posedge i_clock) disable iff (!i_resetn)
         o_core[ch].range_x4 == i_range_x4[ch])
         else $error("channel range bit not forwarded");
      AST_MODE_CH: assert property (@(posedge i_clock) disable iff (!i_resetn)
         o_core[ch].bipolar == i_bipolar)
         else $error("channel mode flag not forwarded");
   end

   // answer mux; unmapped addresses read zero from both sources
   assign o_reg_rdata = (rd_sel_q == DCC_SEL_DATA) ? data_rd_q : bank_rd;
   assign o_reg_rvalid = rvalid_q;
   assign o_core_valid = valid_q;

   // trims hold zero right after reset
   AST_TRIM_RESET: assert property (@(posedge i_clock)
      $rose(i_resetn) |-> (offset == '0 && slope == '0))
      else $error("trims not cleared by reset");

   // offset write to channel 1 keeps the nine low data bits
   AST_OFF_WRITE: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == 4'h5)
      |=> offset[1] == $past(i_reg_wdata[8:0]))
      else $error("offset trim write lost");

   // slope write keeps eight bits
   AST_SLP_WRITE: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == 4'ha)
      |=> slope[2] == $past(i_reg_wdata[7:0]))
      else $error("slope trim write lost");

   // trim readback never shows upper bits
   AST_RESERVED_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr[3:2] != 2'h0)
      |=> (o_reg_rvalid && o_reg_rdata[15:9] == 7'h00))
      else $error("trim readback shows reserved bits");

   // an offset write to channel 0 leaves the channel 3 offset and all slopes alone
   AST_CHAN_INDEP: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == 4'h4)
      |=> ($stable(offset[3]) && $stable(slope)))
      else $error("trim write disturbed another channel");

   // code field from bits 15..2 of the data word
   AST_CODE_FIELD: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == 4'h3)
      |=> data_q[3] == $past(i_reg_wdata[15:2]))
      else $error("channel code field misplaced");

   // load latches the codes and flags the result two edges later
   AST_LOAD_LATCH: assert property (@(posedge i_clock) disable iff (!i_resetn)
      i_load |=> (latch_q == $past(data_q)) ##1 o_core_valid)
      else $error("load did not latch codes or flag the result");

   // range selection follows its input bit
   AST_RANGE: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_core[0].range_x4 == i_range_x4[0])
      else $error("range bit not forwarded");

   // register port checks; a read in the cycle of a write sees the old value
   // reset clears trims and silences both strobes on the next edge
   AST_RESET_STATE: assert property (@(posedge i_clock)
      !i_resetn
      |=> (offset == '0 && slope == '0 && !o_core_valid && !o_reg_rvalid))
      else $error("reset did not clear trims and strobes");

   // exactly one answer per read strobe, on the very next edge
   AST_RVALID_TIMING: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_reg_rvalid == $past(i_reg_rd))
      else $error("read answer not one cycle after the strobe");

   // slope readback keeps its eight upper bits at zero
   AST_SLP_RESERVED: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr[3:2] == 2'h2)
      |=> o_reg_rdata[15:8] == 8'h00)
      else $error("slope readback shows reserved bits");

   // the unmapped indices answer with an all-zero word
   AST_UNMAPPED_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr[3:2] == 2'h3)
      |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");

   // offset readback returns the trim as it stood at the strobe
   AST_OFF_READBACK: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr[3:2] == 2'h1)
      |=> o_reg_rdata[8:0] == $past(offset[i_reg_addr[1:0]]))
      else $error("offset trim readback wrong");

   // slope readback likewise, eight live bits
   AST_SLP_READBACK: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr[3:2] == 2'h2)
      |=> o_reg_rdata[7:0] == $past(slope[i_reg_addr[1:0]]))
      else $error("slope trim readback wrong");

   // code readback puts the code in its field with the low bits zero
   AST_DATA_READBACK: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr[3:2] == 2'h0)
      |=> o_reg_rdata == {$past(data_q[i_reg_addr[1:0]]), 2'h0})
      else $error("channel code readback wrong");

   // input codes change only on a write to a data index
   AST_DATA_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !(i_reg_wr && i_reg_addr[3:2] == 2'h0)
      |=> $stable(data_q))
      else $error("channel code changed without a write");

   // trims change only on a write; reads have no side effect
   AST_TRIM_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !i_reg_wr
      |=> ($stable(offset) && $stable(slope)))
      else $error("trim changed without a write");

   // a slope write to channel 0 leaves the other slopes and all offsets alone
   AST_SLP_CHAN_INDEP: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == 4'h8)
      |=> ($stable(slope[3:1]) && $stable(offset)))
      else $error("slope write disturbed another trim");

   // writes to unmapped indices are dropped; the decode has no spare slot
   AST_UNMAPPED_WRITE: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr[3:2] == 2'h3)
      |=> ($stable(data_q) && $stable(offset) && $stable(slope)))
      else $error("unmapped write changed a register");

   // between loads the latch holds, so data writes never reach the core early
   AST_LATCH_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !i_load
      |=> $stable(latch_q))
      else $error("latch changed without a load");

   // the core strobe only ever follows a load by two edges
   AST_VALID_CAUSE: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_core_valid |-> $past(i_load, 2))
      else $error("core strobe without a load");
endmodule : dcc_top

// file: core/dcc_trim_bank.sv
// Purpose: per-channel offset and slope trim storage with registered read
// Assumes: at most one write per cycle
// Notes: only the live trim bits are stored, so upper bits cannot hold data
`timescale 1ns/1ps
module dcc_trim_bank
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // write side
   input wire logic i_off_we,
   input wire logic i_slp_we,
   input wire logic [1:0] i_wr_chan,
   input wire logic [dcc_pkg::WORD_W-1:0] i_wdata,
   // read side
   input wire logic [1:0] i_rd_chan,
   input wire dcc_pkg::dcc_sel_t i_rd_sel,
   output logic [dcc_pkg::WORD_W-1:0] o_rd_data,
   // live trims to the datapaths
   output logic [dcc_pkg::NCH-1:0][dcc_pkg::OFF_W-1:0] o_offset,
   output logic [dcc_pkg::NCH-1:0][dcc_pkg::SLP_W-1:0] o_slope
);
   import dcc_pkg::*;

   logic [NCH-1:0][OFF_W-1:0] off_q, off_d; // offset trims
   logic [NCH-1:0][SLP_W-1:0] slp_q, slp_d; // slope trims
   logic [WORD_W-1:0] rd_q, rd_d; // read data register

   // next trim values; upper data bits are simply dropped
   always_comb
   begin
      off_d = off_q;
      slp_d = slp_q;
      if (i_off_we)
      begin
         off_d[i_wr_chan] = i_wdata[OFF_W-1:0];
      end
      if (i_slp_we)
      begin
         slp_d[i_wr_chan] = i_wdata[SLP_W-1:0];
      end
   end

   // read mux, unused upper bits forced to zero
   always_comb
   begin
      case (i_rd_sel)
         DCC_SEL_OFF: rd_d = {{(WORD_W-OFF_W){1'b0}}, off_q[i_rd_chan]};
         DCC_SEL_SLP: rd_d = {{(WORD_W-SLP_W){1'b0}}, slp_q[i_rd_chan]};
         default: rd_d = '0;
      endcase
   end

   // registers; trims clear to no adjustment
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         off_q <= {NCH{OFF_RESET}};
         slp_q <= {NCH{SLP_RESET}};
         rd_q <= '0;
      end
      else
      begin
         off_q <= off_d;
         slp_q <= slp_d;
         rd_q <= rd_d;
      end
   end

   assign o_rd_data = rd_q;
   assign o_offset = off_q;
   assign o_slope = slp_q;
endmodule : dcc_trim_bank
